/* File: inc/tone_readout_pkg.sv */
package tone_readout_pkg;

   // ************************************************************
   // guard periods and integrator decay, in enabled cycles of mclk (counts hold while clk_en is low)
   // ************************************************************
   localparam int PRESENT_GUARD_CYCLES = 400;
   localparam int ABSENT_GUARD_CYCLES = 300;
   localparam int ENERGY_DECAY_CYCLES = 200;

   // ************************************************************
   // digit code field and buffering
   // ************************************************************
   localparam int DIGIT_WIDTH = 4;
   localparam int DIGIT_LSB = 0;
   localparam int DIGIT_MSB = 3;
   localparam int FIFO_DEPTH = 16;
   localparam int ACK_PULSES = 4;
   localparam logic [3:0] DIGIT_RESET = 4'h0;

   // low group index 0..3 = 697,770,852,941; high group 0..3 = 1209,1336,1477,1633
   localparam logic [1:0] LOW_941 = 2'h3;
   localparam logic [1:0] HIGH_1633 = 2'h3;
   localparam logic [3:0] CODE_ZERO = 4'hA;
   localparam logic [3:0] CODE_STAR = 4'hB;
   localparam logic [3:0] CODE_HASH = 4'hC;
   localparam logic [3:0] CODE_D = 4'h0;

   // shifter states
   typedef enum logic [1:0] {
      SH_IDLE,
      SH_SHIFT,
      SH_DONE
   } shift_state_t;

endpackage

/* File: design/digit_fifo.sv */
module digit_fifo #(
   parameter int WIDTH = 4,
   parameter int DEPTH = 16
) (
   // clock, reset, enable
   input wire logic mclk,
   input wire logic rst,
   input wire logic clk_en,
   // write side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // read side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);

   localparam int AW = $clog2(DEPTH);

   initial begin
      if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin
         $error("digit_fifo: depth must be a power of two of at least 2");
      end
   end

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wr_ptr;
   logic [AW:0] rd_ptr;
   logic do_write;
   logic do_read;

   // full when pointers differ only in the wrap bit
   assign in_ready = !((wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]));
   assign out_valid = (wr_ptr != rd_ptr);
   assign do_write = clk_en && in_valid && in_ready;
   assign do_read = clk_en && out_valid && out_ready;
   assign out_data = mem[rd_ptr[AW-1:0]];

   // storage array has no reset, only the pointers
   always_ff @(posedge mclk) begin
      if (do_write) begin
         mem[wr_ptr[AW-1:0]] <= in_data;
      end
   end

   // pointer update
   always_ff @(posedge mclk) begin
      if (rst) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end else begin
         if (do_write) begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (do_read) begin
            rd_ptr <= rd_ptr + 1'b1;
         end
      end
   end

endmodule

/* File: design/input_sync.sv */
module input_sync #(
   parameter int WIDTH = 1
) (
   // clock and enable
   input wire logic mclk,
   input wire logic rst,
   input wire logic clk_en,
   // asynchronous in, synchronised out
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] stage1;

   initial begin
      if (WIDTH < 1) begin
         $error("input_sync: width must be at least 1");
      end
   end

   // two flops; the first is read only by the second
   always_ff @(posedge mclk) begin
      if (rst) begin
         stage1 <= '0;
         sync_out <= '0;
      end else if (clk_en) begin
         stage1 <= async_in;
         sync_out <= stage1;
      end
   end

endmodule

/* File: design/tone_digit_serial_readout.sv */
module tone_digit_serial_readout #(
   parameter bit DELAYED_VARIANT = 1'b1,
   parameter int PRESENT_GUARD = tone_readout_pkg::PRESENT_GUARD_CYCLES,
   parameter int ABSENT_GUARD = tone_readout_pkg::ABSENT_GUARD_CYCLES,
   parameter int ENERGY_DECAY = tone_readout_pkg::ENERGY_DECAY_CYCLES,
   parameter int FIFO_DEPTH = tone_readout_pkg::FIFO_DEPTH
) (
   // clock, reset, enable
   input wire logic mclk,
   input wire logic rst,
   input wire logic clk_en,
   // detector front end, same clock domain
   input wire logic low_group_valid,
   input wire logic high_group_valid,
   input wire logic [1:0] low_group_index,
   input wire logic [1:0] high_group_index,
   input wire logic energy_above,
   // pins from the host
   input wire logic ack_pin,
   input wire logic sleep_request,
   // pins to the host
   output logic early_tone_flag,
   output logic validated_tone_flag,
   output logic serial_digit_cadence_out,
   // status
   output logic powered_down,
   output logic digit_dropped
);

   // ************************************************************
   // parameter checks
   // ************************************************************
   initial begin
      if (PRESENT_GUARD < 1 || ABSENT_GUARD < 1 || ENERGY_DECAY < 1) begin
         $error("tone_digit_serial_readout: guard and decay counts must be at least 1");
      end
      if (PRESENT_GUARD > 65535 || ABSENT_GUARD > 65535 || ENERGY_DECAY > 65535) begin
         $error("tone_digit_serial_readout: counts must fit 16 bits");
      end
   end

   localparam logic [15:0] PRESENT_LAST = 16'(PRESENT_GUARD - 1);
   localparam logic [15:0] ABSENT_LAST = 16'(ABSENT_GUARD - 1);
   localparam logic [15:0] DECAY_LAST = 16'(ENERGY_DECAY - 1);

   // ************************************************************
   // pin synchronisers
   // ************************************************************
   logic ack_s;
   logic sleep_s;

   input_sync #(
      .WIDTH(2)
   ) u_pin_sync (
      .mclk(mclk),
      .rst(rst),
      .clk_en(clk_en),
      .async_in({ack_pin, sleep_request}),
      .sync_out({ack_s, sleep_s})
   );

   logic ack_d;
   logic sleep_d;
   logic ack_rise;
   logic ack_fall;

   // edge history taken from the second sync stage only
   always_ff @(posedge mclk) begin
      if (rst) begin
         ack_d <= 1'b0;
         sleep_d <= 1'b0;
      end else if (clk_en) begin
         ack_d <= ack_s;
         sleep_d <= sleep_s;
      end
   end

   assign ack_rise = ack_s && !ack_d;
   assign ack_fall = !ack_s && ack_d;

   // ************************************************************
   // powerdown
   // ************************************************************
   // entry on the rising edge only; leaves when the request drops
   always_ff @(posedge mclk) begin
      if (rst) begin
         powered_down <= 1'b0;
      end else if (clk_en) begin
         if (sleep_s && !sleep_d) begin
            powered_down <= 1'b1;
         end else if (!sleep_s) begin
            powered_down <= 1'b0;
         end
      end
   end

   // ************************************************************
   // early steering and digit lookup
   // ************************************************************
   logic dual_tone;
   logic [3:0] next_code;

   assign dual_tone = low_group_valid && high_group_valid && !powered_down;

   // table lookup: row-major digits 1..9, then the 941 row and 1633 column
   always_comb begin
      next_code = {2'b00, low_group_index} * 4'h3 + {2'b00, high_group_index} + 4'h1;
      if (high_group_index == tone_readout_pkg::HIGH_1633) begin
         if (low_group_index == tone_readout_pkg::LOW_941) begin
            next_code = tone_readout_pkg::CODE_D;
         end else begin
            next_code = 4'hD + {2'b00, low_group_index};
         end
      end else if (low_group_index == tone_readout_pkg::LOW_941) begin
         unique case (high_group_index)
            2'h0: next_code = tone_readout_pkg::CODE_STAR;
            2'h1: next_code = tone_readout_pkg::CODE_ZERO;
            default: next_code = tone_readout_pkg::CODE_HASH;
         endcase
      end
   end

   logic [3:0] decoded_digit;

   // early flag follows the dual tone condition directly, with the digit it names
   always_ff @(posedge mclk) begin
      if (rst) begin
         early_tone_flag <= 1'b0;
         decoded_digit <= tone_readout_pkg::DIGIT_RESET;
      end else if (clk_en) begin
         early_tone_flag <= dual_tone;
         if (dual_tone) begin
            decoded_digit <= next_code;
         end
      end
   end

   // ************************************************************
   // delayed steering guard counter
   // ************************************************************
   logic delayed_flag;
   logic [15:0] guard_count;

   // counts the present guard while low and the absent guard while high
   always_ff @(posedge mclk) begin
      if (rst) begin
         delayed_flag <= 1'b0;
         guard_count <= 16'h0000;
      end else if (clk_en) begin
         if (powered_down) begin
            delayed_flag <= 1'b0;
            guard_count <= 16'h0000;
         end else if (!delayed_flag) begin
            if (!early_tone_flag) begin
               guard_count <= 16'h0000;
            end else if (guard_count == PRESENT_LAST) begin
               delayed_flag <= 1'b1;
               guard_count <= 16'h0000;
            end else begin
               guard_count <= guard_count + 16'h0001;
            end
         end else begin
            if (early_tone_flag) begin
               guard_count <= 16'h0000;
            end else if (guard_count == ABSENT_LAST) begin
               delayed_flag <= 1'b0;
               guard_count <= 16'h0000;
            end else begin
               guard_count <= guard_count + 16'h0001;
            end
         end
      end
   end

   logic steer;

   // variant chosen at build time
   assign steer = DELAYED_VARIANT ? delayed_flag : early_tone_flag;
   assign validated_tone_flag = DELAYED_VARIANT ? delayed_flag : 1'b0;

   // ************************************************************
   // digit buffering
   // ************************************************************
   logic steer_d;
   logic steer_rise;
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic fifo_pop;
   logic [3:0] fifo_out_data;

   always_ff @(posedge mclk) begin
      if (rst) begin
         steer_d <= 1'b0;
      end else if (clk_en) begin
         steer_d <= steer;
      end
   end

   assign steer_rise = steer && !steer_d;

   // a full queue loses the digit; reported so software can count it
   assign digit_dropped = steer_rise && !fifo_in_ready;

   digit_fifo #(
      .WIDTH(tone_readout_pkg::DIGIT_WIDTH),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .mclk(mclk),
      .rst(rst),
      .clk_en(clk_en),
      .in_valid(steer_rise && !powered_down),
      .in_ready(fifo_in_ready),
      .in_data(decoded_digit),
      .out_valid(fifo_out_valid),
      .out_ready(fifo_pop),
      .out_data(fifo_out_data)
   );

   // ************************************************************
   // acknowledge shifter
   // ************************************************************
   tone_readout_pkg::shift_state_t shift_state;
   logic [3:0] shift_reg;
   logic [2:0] pulse_count;
   logic digit_window;
   logic armed;

   // a digit can be read only while armed: after a steering rise, or after a full read that left digits queued
   assign fifo_pop = clk_en && (shift_state == tone_readout_pkg::SH_IDLE) && ack_rise
      && armed && fifo_out_valid && !powered_down;

   // armed by each steering rise; a completed read disarms only if the queue is then empty
   always_ff @(posedge mclk) begin
      if (rst) begin
         armed <= 1'b0;
      end else if (clk_en) begin
         if (steer_rise) begin
            armed <= 1'b1;
         end else if (shift_state == tone_readout_pkg::SH_SHIFT && ack_fall
            && pulse_count == 3'(tone_readout_pkg::ACK_PULSES)) begin
            armed <= fifo_out_valid;
         end
      end
   end

   // capture, shift and window control
   always_ff @(posedge mclk) begin
      if (rst) begin
         shift_state <= tone_readout_pkg::SH_IDLE;
         shift_reg <= tone_readout_pkg::DIGIT_RESET;
         pulse_count <= 3'h0;
         digit_window <= 1'b0;
      end else if (clk_en) begin
         if (powered_down) begin
            shift_state <= tone_readout_pkg::SH_IDLE;
            pulse_count <= 3'h0;
            digit_window <= 1'b0;
         end else begin
            unique case (shift_state)
               tone_readout_pkg::SH_IDLE: begin
                  if (fifo_pop) begin
                     shift_reg <= fifo_out_data;
                     pulse_count <= 3'h1;
                     digit_window <= 1'b1;
                     shift_state <= tone_readout_pkg::SH_SHIFT;
                  end
               end
               tone_readout_pkg::SH_SHIFT: begin
                  // no new capture can happen until four pulses are seen
                  if (ack_rise) begin
                     shift_reg <= {1'b0, shift_reg[tone_readout_pkg::DIGIT_MSB:1]};
                     pulse_count <= pulse_count + 3'h1;
                  end else if (ack_fall && pulse_count == 3'(tone_readout_pkg::ACK_PULSES)) begin
                     digit_window <= 1'b0;
                     shift_state <= tone_readout_pkg::SH_DONE;
                  end
               end
               tone_readout_pkg::SH_DONE: begin
                  // held for one cycle only, then back to idle, where a surplus pulse pops the next digit if armed
                  shift_state <= tone_readout_pkg::SH_IDLE;
                  pulse_count <= 3'h0;
               end
               default: begin
                  shift_state <= tone_readout_pkg::SH_IDLE;
               end
            endcase
         end
      end
   end

   // ************************************************************
   // energy integrator
   // ************************************************************
   logic energy_flag;
   logic [15:0] decay_count;

   // retriggerable hold: high at once, low after a quiet decay interval
   always_ff @(posedge mclk) begin
      if (rst) begin
         energy_flag <= 1'b0;
         decay_count <= 16'h0000;
      end else if (clk_en) begin
         if (powered_down) begin
            energy_flag <= 1'b0;
            decay_count <= 16'h0000;
         end else if (energy_above) begin
            energy_flag <= 1'b1;
            decay_count <= 16'h0000;
         end else if (energy_flag) begin
            if (decay_count == DECAY_LAST) begin
               energy_flag <= 1'b0;
               decay_count <= 16'h0000;
            end else begin
               decay_count <= decay_count + 16'h0001;
            end
         end
      end
   end

   // ************************************************************
   // output pin multiplexer
   // ************************************************************
   // registered so the pin never glitches between the two sources
   always_ff @(posedge mclk) begin
      if (rst) begin
         serial_digit_cadence_out <= 1'b0;
      end else if (clk_en) begin
         if (powered_down) begin
            serial_digit_cadence_out <= 1'b0;
         end else if (digit_window || fifo_pop) begin
            serial_digit_cadence_out <= fifo_pop ? fifo_out_data[tone_readout_pkg::DIGIT_LSB]
               : (ack_rise ? shift_reg[1] : shift_reg[0]);
         end else begin
            serial_digit_cadence_out <= energy_flag;
         end
      end
   end

endmodule

/* File: testbench/readout_chk.sv */
module readout_chk #(
   parameter int PRESENT_GUARD = 4,
   parameter int ABSENT_GUARD = 4,
   parameter int ENERGY_DECAY = 4
) (
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // front end
   input wire logic low_group_valid,
   input wire logic high_group_valid,
   input wire logic energy_above,
   // host pins
   input wire logic ack_pin,
   input wire logic sleep_request,
   // outputs
   input wire logic early_tone_flag,
   input wire logic validated_tone_flag,
   input wire logic serial_digit_cadence_out,
   input wire logic powered_down
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge mclk);
   endclocking
   default disable iff (rst);

   // ****
   // helper counters
   // ****
   logic [9:0] hi_run;
   logic [9:0] lo_run;
   logic [9:0] quiet_e;
   logic [3:0] ack_quiet;
   logic [1:0] ack_phase;
   logic ack_prev;

   // run lengths saturate so a long idle never wraps back into range
   always_ff @(posedge mclk) begin
      if (rst) begin
         hi_run <= 10'h000;
         lo_run <= 10'h000;
         quiet_e <= 10'h000;
      end else begin
         hi_run <= early_tone_flag ? hi_run + (hi_run != 10'h3FF) : 10'h000;
         lo_run <= early_tone_flag ? 10'h000 : lo_run + (lo_run != 10'h3FF);
         quiet_e <= energy_above ? 10'h000 : quiet_e + (quiet_e != 10'h3FF);
      end
   end

   // raw pulse phase; only valid while the host sends whole groups of four
   always_ff @(posedge mclk) begin
      if (rst) begin
         ack_prev <= 1'b0;
         ack_phase <= 2'h0;
         ack_quiet <= 4'h0;
      end else begin
         ack_prev <= ack_pin;
         ack_phase <= ack_phase + 2'(ack_pin && !ack_prev);
         ack_quiet <= ack_pin ? 4'h0 : ack_quiet + (ack_quiet != 4'hF);
      end
   end

   // ****
   // assertions
   // ****
   a_early_follows_tone: assert property (low_group_valid && high_group_valid && !powered_down && !sleep_request
      |=> early_tone_flag) else $error("early flag missed a dual tone");
   a_early_drops_loss: assert property (!(low_group_valid && high_group_valid) |=> !early_tone_flag)
      else $error("early flag stayed up without dual tone");
   a_valid_after_guard: assert property ($rose(validated_tone_flag) |-> early_tone_flag && hi_run >= PRESENT_GUARD)
      else $error("validated flag rose before the present guard");
   a_valid_absent_guard: assert property ($fell(validated_tone_flag) && !powered_down && !sleep_request
      |-> lo_run >= ABSENT_GUARD) else $error("validated flag fell before the absent guard");
   a_valid_holds_early: assert property (validated_tone_flag && early_tone_flag && !sleep_request
      |=> validated_tone_flag || powered_down) else $error("validated flag fell with early flag up");
   a_sleep_quiet: assert property (powered_down [*3]
      |-> !early_tone_flag && !validated_tone_flag && !serial_digit_cadence_out)
      else $error("outputs not low in powerdown");
   a_energy_shows: assert property ((ack_phase == 2'h0 && ack_quiet > 4'h7 && !powered_down && !sleep_request
      && energy_above) [*4] |-> serial_digit_cadence_out) else $error("energy not shown on serial pin");
   a_energy_decay: assert property ($fell(serial_digit_cadence_out) && ack_phase == 2'h0 && ack_quiet > 4'h7
      && !powered_down && !sleep_request |-> quiet_e >= ENERGY_DECAY) else $error("energy fell before decay");
endmodule

bind tone_digit_serial_readout readout_chk #(
   .PRESENT_GUARD(PRESENT_GUARD), .ABSENT_GUARD(ABSENT_GUARD), .ENERGY_DECAY(ENERGY_DECAY)
) chk (
   .mclk(mclk), .rst(rst), .low_group_valid(low_group_valid), .high_group_valid(high_group_valid),
   .energy_above(energy_above), .ack_pin(ack_pin), .sleep_request(sleep_request),
   .early_tone_flag(early_tone_flag), .validated_tone_flag(validated_tone_flag),
   .serial_digit_cadence_out(serial_digit_cadence_out), .powered_down(powered_down)
);

/* File: testbench/host_model.sv */
module host_model (
   // clock
   input wire logic mclk,
   // acknowledge pin out, serial pin in
   output logic ack_pin,
   input wire logic serial_digit_cadence_out
);
   timeunit 1ns;
   timeprecision 1ns;

   // acknowledge idles low, also across any sleep request
   initial ack_pin = 1'b0;

   // n pulses, each high for hold cycles and low for six; the bit is taken just before the fall
   // a partial group is finished by calling again with the missing count
   task automatic pulse_bits(input int n, input int hold, inout logic [3:0] bits);
      for (int i = 0; i < n; i++) begin
         @(posedge mclk);
         ack_pin <= 1'b1;
         repeat (hold) @(posedge mclk);
         bits = {serial_digit_cadence_out, bits[3:1]};
         ack_pin <= 1'b0;
         repeat (5) @(posedge mclk);
      end
   endtask
endmodule

/* File: testbench/tb_top.sv */
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;

   // ****
   // signals and instances
   // ****
   logic mclk, rst, clk_en, low_group_valid, high_group_valid, energy_above, ack_pin, sleep_request;
   logic [1:0] low_group_index, high_group_index;
   logic early_tone_flag, validated_tone_flag, serial_digit_cadence_out, powered_down, digit_dropped;
   logic [3:0] v;
   logic ack_e, early_e, validated_e, serial_e;
   int failures, checks, drops, cycles;

   // short guards keep the run brief; every expectation follows them
   tone_digit_serial_readout #(
      .DELAYED_VARIANT(1'b1), .PRESENT_GUARD(8), .ABSENT_GUARD(6), .ENERGY_DECAY(5),
      .FIFO_DEPTH(tone_readout_pkg::FIFO_DEPTH)
   ) dut (
      .mclk(mclk), .rst(rst), .clk_en(clk_en), .low_group_valid(low_group_valid),
      .high_group_valid(high_group_valid), .low_group_index(low_group_index),
      .high_group_index(high_group_index), .energy_above(energy_above), .ack_pin(ack_pin),
      .sleep_request(sleep_request), .early_tone_flag(early_tone_flag),
      .validated_tone_flag(validated_tone_flag), .serial_digit_cadence_out(serial_digit_cadence_out),
      .powered_down(powered_down), .digit_dropped(digit_dropped)
   );
   host_model host (.mclk(mclk), .ack_pin(ack_pin), .serial_digit_cadence_out(serial_digit_cadence_out));

   // early variant beside it, read by a host of its own so its queue stays apart
   tone_digit_serial_readout #(
      .DELAYED_VARIANT(1'b0), .PRESENT_GUARD(8), .ABSENT_GUARD(6), .ENERGY_DECAY(5),
      .FIFO_DEPTH(tone_readout_pkg::FIFO_DEPTH)
   ) dut_early (
      .mclk(mclk), .rst(rst), .clk_en(clk_en), .low_group_valid(low_group_valid),
      .high_group_valid(high_group_valid), .low_group_index(low_group_index),
      .high_group_index(high_group_index), .energy_above(energy_above), .ack_pin(ack_e),
      .sleep_request(sleep_request), .early_tone_flag(early_e), .validated_tone_flag(validated_e),
      .serial_digit_cadence_out(serial_e), .powered_down(), .digit_dropped()
   );
   host_model host_e (.mclk(mclk), .ack_pin(ack_e), .serial_digit_cadence_out(serial_e));

   // 100 ns period
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end

   // drop pulses and a cycle ceiling well above the expected run of about 1600 cycles
   always @(posedge mclk) begin
      cycles++;
      if (digit_dropped === 1'b1)
         drops++;
      if (cycles == 12000) begin
         failures++;
         give_verdict();
      end
   end

   // ****
   // helpers
   // ****
   task automatic check(input string what, input logic [3:0] exp, input logic [3:0] got);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask

   task automatic give_verdict();
      if (failures == 0 && checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   function automatic logic [3:0] code_of(input int l, input int h);
      if (h == 3)
         return (l == 3) ? 4'h0 : 4'hD + 4'(l);
      if (l == 3)
         return (h == 0) ? 4'hB : (h == 1) ? 4'hA : 4'hC;
      return 4'(l * 3 + h + 1);
   endfunction

   task automatic tones(input logic on);
      @(posedge mclk);
      low_group_valid <= on;
      high_group_valid <= on;
   endtask

   // one tone burst; with dip it drops out briefly to restart the absent guard
   task automatic steer(input int l, input int h, input bit dip);
      int i;
      low_group_index <= 2'(l);
      high_group_index <= 2'(h);
      tones(1'b1);
      for (i = 0; i < 40 && validated_tone_flag !== 1'b1; i++)
         @(posedge mclk);
      check("early", 4'h1, {3'h0, early_tone_flag});
      check("validated", 4'h1, {3'h0, validated_tone_flag});
      if (dip) begin
         tones(1'b0);
         repeat (3) @(posedge mclk);
         tones(1'b1);
         repeat (2) @(posedge mclk);
      end
      tones(1'b0);
      if (dip) begin
         repeat (4) @(posedge mclk);
         check("validated", 4'h1, {3'h0, validated_tone_flag});
      end
      for (i = 0; i < 40 && validated_tone_flag !== 1'b0; i++)
         @(posedge mclk);
      check("validated", 4'h0, {3'h0, validated_tone_flag});
      check("early", 4'h0, {3'h0, early_tone_flag});
   endtask

   // ****
   // scenarios
   // ****
   task automatic energy_case();
      @(posedge mclk);
      energy_above <= 1'b1;
      repeat (6) @(posedge mclk);
      check("energy", 4'h1, {3'h0, serial_digit_cadence_out});
      energy_above <= 1'b0;
      repeat (2) @(posedge mclk);
      energy_above <= 1'b1;
      repeat (2) @(posedge mclk);
      energy_above <= 1'b0;
      repeat (3) @(posedge mclk);
      check("energy", 4'h1, {3'h0, serial_digit_cadence_out});
      repeat (12) @(posedge mclk);
      check("energy", 4'h0, {3'h0, serial_digit_cadence_out});
      // a low enable must freeze the decay count as well
      energy_above <= 1'b1;
      repeat (3) @(posedge mclk);
      energy_above <= 1'b0;
      clk_en <= 1'b0;
      repeat (20) @(posedge mclk);
      check("frozen", 4'h1, {3'h0, serial_digit_cadence_out});
      clk_en <= 1'b1;
      repeat (12) @(posedge mclk);
      check("energy", 4'h0, {3'h0, serial_digit_cadence_out});
   endtask

   // early variant: a short burst steers alone, too short for the delayed build
   task automatic early_case();
      low_group_index <= 2'h0;
      high_group_index <= 2'h3;
      tones(1'b1);
      repeat (3) @(posedge mclk);
      check("early", 4'h1, {3'h0, early_e});
      tones(1'b0);
      repeat (2) @(posedge mclk);
      check("early", 4'h0, {3'h0, early_e});
      check("validated", 4'h0, {3'h0, validated_e});
      host_e.pulse_bits(4, 5, v);
      check("digit", code_of(0, 3), v);
   endtask

   // the host stalls while every code is queued, one more overflows, then all drain in order
   task automatic fill_case();
      drops = 0;
      for (int k = 0; k < 16; k++)
         steer(k / 4, k % 4, 1'b0);
      steer(0, 0, 1'b0);
      check("drops", 4'h1, 4'(drops));
      for (int k = 0; k < 16; k++) begin
         host.pulse_bits(4, 5 + 4 * (k % 2), v);
         check("digit", code_of(k / 4, k % 4), v);
      end
   endtask

   // a burst arriving mid read must not displace the digit being shifted
   task automatic partial_case();
      steer(3, 2, 1'b0);
      host.pulse_bits(2, 5, v);
      steer(1, 1, 1'b0);
      host.pulse_bits(2, 9, v);
      check("digit", code_of(3, 2), v);
      steer(0, 1, 1'b0);
      host.pulse_bits(4, 5, v);
      check("digit", code_of(1, 1), v);
      host.pulse_bits(4, 5, v);
      check("digit", code_of(0, 1), v);
      host.pulse_bits(4, 5, v);
      check("extra", 4'h0, v);
   endtask

   task automatic sleep_case();
      @(posedge mclk);
      energy_above <= 1'b1;
      tones(1'b1);
      repeat (20) @(posedge mclk);
      sleep_request <= 1'b1;
      repeat (8) @(posedge mclk);
      check("sleep", 4'h1, {3'h0, powered_down});
      check("outs", 4'h0, {1'h0, early_tone_flag, validated_tone_flag, serial_digit_cadence_out});
      tones(1'b0);
      energy_above <= 1'b0;
      repeat (3) @(posedge mclk);
      sleep_request <= 1'b0;
      repeat (10) @(posedge mclk);
      check("sleep", 4'h0, {3'h0, powered_down});
   endtask

   // ****
   // main sequence
   // ****
   initial begin
      {rst, clk_en} = 2'h3;
      {low_group_valid, high_group_valid, energy_above, sleep_request} = 4'h0;
      {low_group_index, high_group_index} = 4'h0;
      repeat (3) @(posedge mclk);
      rst <= 1'b0;
      repeat (3) @(posedge mclk);
      energy_case();
      early_case();
      steer(2, 1, 1'b1);
      host.pulse_bits(4, 5, v);
      check("digit", code_of(2, 1), v);
      fill_case();
      partial_case();
      sleep_case();
      give_verdict();
   end
endmodule
